// ---- src/bml_buf.sv ----
// Small shift-style buffer, head entry always in the first register
`timescale 1ns/1ps
`default_nettype none
module bml_buf #(
	parameter int W     = 40,
	parameter int DEPTH = 2
) (
	input  wire logic         mclk_i,
	input  wire logic         reset_n_i,
	input  wire logic         flush_i,
	input  wire logic         in_valid_i,
	input  wire logic [W-1:0] in_data_i,
	output logic              in_ready_o,
	output logic              out_valid_o,
	output logic [W-1:0]      out_data_o,
	input  wire logic         out_ready_i
);
	localparam int CW = $clog2(DEPTH + 1);
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;
	logic [W-1:0]  ent_r [DEPTH];
	logic          push;
	logic          pop;

	// Handshakes; full is honest, so the source stalls
	assign in_ready_o  = (cnt_r != CW'(DEPTH));
	assign out_valid_o = (cnt_r != '0);
	assign out_data_o  = ent_r[0];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	// Occupancy count
	always_comb begin
		cnt_nxt = cnt_r;
		if (flush_i) begin
			cnt_nxt = '0;
		end else if (push & ~pop) begin
			cnt_nxt = cnt_r + CW'(1);
		end else if (pop & ~push) begin
			cnt_nxt = cnt_r - CW'(1);
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	// Each entry shifts toward the head on pop; only the entry at the free tail slot loads on push
	for (genvar i = 0; i < DEPTH; i++) begin : g_ent
		logic [W-1:0] ent_nxt;
		logic [W-1:0] ent_up;
		// Entry above this one, empty past the top
		if (i + 1 < DEPTH) begin : g_up
			assign ent_up = ent_r[i+1];
		end else begin : g_top
			assign ent_up = '0;
		end
		always_comb begin
			ent_nxt = ent_r[i];
			if (pop) begin
				if (push && (CW'(i + 1) == cnt_r)) begin
					ent_nxt = in_data_i;
				end else begin
					ent_nxt = ent_up;
				end
			end else if (push && (CW'(i) == cnt_r)) begin
				ent_nxt = in_data_i;
			end
		end
		always_ff @(posedge mclk_i or negedge reset_n_i) begin
			if (!reset_n_i) begin
				ent_r[i] <= '0;
			end else begin
				ent_r[i] <= ent_nxt;
			end
		end
	end
endmodule
`default_nettype wire

// ---- src/bml_loader.sv ----
// Boot mode loader: pin capture, serial and flash block loading, core release
`timescale 1ns/1ps
`default_nettype none
module bml_loader (
	input  wire logic        mclk_i,
	input  wire logic        reset_n_i,
	input  wire logic        sw_reset_i,
	input  wire logic        bypass_on_sw_reset_i,
	input  wire logic        core_b_hold_i,
	input  wire logic [1:0]  boot_select_pins_i,
	output logic             serial_boot_chip_select_flag_n_o,
	output logic             spi_sck_o,
	output logic             spi_mosi_o,
	input  wire logic        spi_miso_i,
	output logic [23:0]      flash_addr_o,
	output logic             flash_bank0_sel_n_o,
	output logic             flash_rd_n_o,
	input  wire logic [7:0]  flash_data_i,
	output logic [3:0]       ext_setup_cyc_o,
	output logic [3:0]       ext_access_cyc_o,
	output logic [3:0]       ext_hold_cyc_o,
	output logic             ext_pack16_o,
	output logic [1:0]       boot_mode_o,
	output logic             mem_wr_valid_o,
	output logic [31:0]      mem_wr_addr_o,
	output logic [7:0]       mem_wr_data_o,
	input  wire logic        mem_wr_ready_i,
	output logic             core_a_run_o,
	output logic [31:0]      core_a_start_addr_o,
	output logic             core_b_run_o,
	output logic [31:0]      core_b_start_addr_o
);
	localparam logic [3:0] HALF = 4'(bml_pkg::SPI_HALF_CYC - 1);

	// Synchronisers for pins from outside the clock domain
	logic [1:0] pins_m, pins_s;
	logic       miso_m, miso_s;
	logic [7:0] fdat_m, fdat_s;
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pins_m <= 2'h0;
			pins_s <= 2'h0;
			miso_m <= 1'b0;
			miso_s <= 1'b0;
			fdat_m <= 8'h00;
			fdat_s <= 8'h00;
		end else begin
			pins_m <= boot_select_pins_i;
			pins_s <= pins_m;
			miso_m <= spi_miso_i;
			miso_s <= miso_m;
			fdat_m <= flash_data_i;
			fdat_s <= fdat_m;
		end
	end

	bml_pkg::bml_state_t st_r, st_nxt;
	logic [1:0]  wait_r, wait_nxt, mode_r, mode_nxt;
	logic        cs_n_r, cs_n_nxt, sck_r, sck_nxt, mosi_r, mosi_nxt, hi_r, hi_nxt;
	logic [23:0] tx_r, tx_nxt;
	logic [7:0]  rx_r, rx_nxt;
	logic [4:0]  bits_r, bits_nxt;
	logic [3:0]  div_r, div_nxt, fcnt_r, fcnt_nxt;
	logic [23:0] fa_r, fa_nxt;
	logic        fbank_n_r, fbank_n_nxt, frd_n_r, frd_n_nxt, busy_r, busy_nxt;
	logic [1:0]  fph_r, fph_nxt;
	logic [3:0]  hidx_r, hidx_nxt;
	logic [31:0] blk_addr_r, blk_addr_nxt, blk_cnt_r, blk_cnt_nxt;
	logic        last_r, last_nxt;
	logic [3:0]  setup_r, setup_nxt, acc_r, acc_nxt, hold_r, hold_nxt;
	logic        pack_r, pack_nxt, a_run_r, a_run_nxt, b_run_r, b_run_nxt;
	logic [31:0] a_pc_r, a_pc_nxt;
	logic        use_flash, done, start_byte, start_cmd, push_v, buf_rdy;
	logic [7:0]  byte_v;

	// Engine status seen by the sequencer
	assign use_flash = (mode_r == bml_pkg::MODE_FLASH);
	assign done   = busy_r & (use_flash ? (fph_r == bml_pkg::PH_HOLD && fcnt_r == 4'h0)
	                                    : (hi_r && div_r == 4'h0 && bits_r == 5'h01));
	assign byte_v = use_flash ? rx_r : {rx_r[6:0], miso_s};

	// Byte engine, sequencer and software reset handling
	always_comb begin
		st_nxt = st_r;       wait_nxt = wait_r;     mode_nxt = mode_r;
		cs_n_nxt = cs_n_r;   sck_nxt = sck_r;       mosi_nxt = mosi_r;
		hi_nxt = hi_r;       tx_nxt = tx_r;         rx_nxt = rx_r;
		bits_nxt = bits_r;   div_nxt = div_r;       fcnt_nxt = fcnt_r;
		fa_nxt = fa_r;       fbank_n_nxt = fbank_n_r;
		frd_n_nxt = frd_n_r; busy_nxt = busy_r;     fph_nxt = fph_r;
		hidx_nxt = hidx_r;   blk_addr_nxt = blk_addr_r;
		blk_cnt_nxt = blk_cnt_r;                    last_nxt = last_r;
		setup_nxt = setup_r; acc_nxt = acc_r;       hold_nxt = hold_r;
		pack_nxt = pack_r;   a_run_nxt = a_run_r;   b_run_nxt = b_run_r;
		a_pc_nxt = a_pc_r;
		start_byte = 1'b0;
		start_cmd  = 1'b0;
		push_v     = 1'b0;
		// Serial engine: mode 0, data out while clock low, sampled at end of high phase
		if (busy_r && !use_flash) begin
			if (div_r != 4'h0) begin
				div_nxt = div_r - 4'h1;
			end else if (!hi_r) begin
				div_nxt = HALF;
				sck_nxt = 1'b1;
				hi_nxt  = 1'b1;
			end else begin
				div_nxt  = HALF;
				sck_nxt  = 1'b0;
				hi_nxt   = 1'b0;
				rx_nxt   = byte_v;
				tx_nxt   = {tx_r[22:0], 1'b0};
				mosi_nxt = tx_r[22];
				bits_nxt = bits_r - 5'h01;
				busy_nxt = (bits_r != 5'h01);
			end
		end
		// Flash engine: bank 0 select, setup, read strobe, hold
		if (busy_r && use_flash) begin
			if (fcnt_r != 4'h0) begin
				fcnt_nxt = fcnt_r - 4'h1;
			end else if (fph_r == bml_pkg::PH_SETUP) begin
				fph_nxt   = bml_pkg::PH_ACC;
				frd_n_nxt = 1'b0;
				fcnt_nxt  = setup_r == 4'h0 ? 4'h0 : acc_r - 4'h1; // see RQ4
			end else if (fph_r == bml_pkg::PH_ACC) begin
				fph_nxt   = bml_pkg::PH_HOLD;
				frd_n_nxt = 1'b1;
				rx_nxt    = fdat_s;
				fcnt_nxt  = hold_r - 4'h1; // see RQ4
			end else begin
				fbank_n_nxt = 1'b1;
				fa_nxt      = fa_r + 24'h00_0001;
				busy_nxt    = 1'b0;
			end
		end
		case (st_r)
			bml_pkg::ST_WAIT: begin
				if (wait_r != 2'h0) begin
					wait_nxt = wait_r - 2'h1;
				end else begin
					mode_nxt = pins_s; // see RQ2
					case (pins_s) // see RQ1
						bml_pkg::MODE_DIRECT: begin
							setup_nxt = bml_pkg::EXT_SETUP_CYC; // see RQ4
							acc_nxt   = bml_pkg::EXT_ACC_CYC;
							hold_nxt  = bml_pkg::EXT_HOLD_CYC;
							pack_nxt  = 1'b1; // see RQ3
							a_pc_nxt  = bml_pkg::EXT_START;
							a_run_nxt = 1'b1;
							st_nxt    = bml_pkg::ST_RUN;
						end
						bml_pkg::MODE_FLASH: begin
							setup_nxt = bml_pkg::EXT_SETUP_CYC; // see RQ4
							acc_nxt   = bml_pkg::EXT_ACC_CYC;
							hold_nxt  = bml_pkg::EXT_HOLD_CYC;
							fa_nxt    = 24'h00_0000; // see RQ5
							hidx_nxt  = 4'h0;
							st_nxt    = bml_pkg::ST_HDR;
						end
						bml_pkg::MODE_SERIAL: begin
							cs_n_nxt  = 1'b0; // see RQ6
							start_cmd = 1'b1;
							st_nxt    = bml_pkg::ST_CMD;
						end
						default: begin
							st_nxt = bml_pkg::ST_HALT;
						end
					endcase
				end
			end
			bml_pkg::ST_CMD: begin
				if (done) begin
					hidx_nxt = 4'h0;
					st_nxt   = bml_pkg::ST_HDR;
				end
			end
			bml_pkg::ST_HDR: begin
				start_byte = ~busy_r;
				if (done) begin // see RQ9
					hidx_nxt = hidx_r + 4'h1;
					if (hidx_r < bml_pkg::HDR_CNT_IDX) begin
						blk_addr_nxt = {byte_v, blk_addr_r[31:8]};
					end else if (hidx_r < bml_pkg::HDR_FLAG_IDX) begin
						blk_cnt_nxt = {byte_v, blk_cnt_r[31:8]};
					end else begin
						last_nxt = byte_v[bml_pkg::HDR_LAST_BIT];
						hidx_nxt = 4'h0;
						if (blk_cnt_r != 32'h0000_0000) begin
							st_nxt = bml_pkg::ST_PAY;
						end else if (byte_v[bml_pkg::HDR_LAST_BIT]) begin
							st_nxt = bml_pkg::ST_DRAIN;
						end
					end
				end
			end
			bml_pkg::ST_PAY: begin
				start_byte = ~busy_r & buf_rdy;
				if (done) begin // see RQ7
					push_v       = 1'b1;
					blk_addr_nxt = blk_addr_r + 32'h0000_0001;
					blk_cnt_nxt  = blk_cnt_r - 32'h0000_0001;
					if (blk_cnt_r == 32'h0000_0001) begin
						st_nxt = last_r ? bml_pkg::ST_DRAIN : bml_pkg::ST_HDR;
					end
				end
			end
			bml_pkg::ST_DRAIN: begin
				cs_n_nxt = 1'b1; // see RQ13
				if (!mem_wr_valid_o) begin
					a_pc_nxt  = bml_pkg::L1_START; // see RQ10
					a_run_nxt = 1'b1;
					st_nxt    = bml_pkg::ST_RUN;
				end
			end
			bml_pkg::ST_RUN: begin
				b_run_nxt = b_run_r | ~core_b_hold_i; // see RQ11
			end
			default: begin
				st_nxt = st_r;
			end
		endcase
		// Start a transfer: command plus address, or one byte
		if (start_cmd) begin
			tx_nxt   = {bml_pkg::SPI_RD_CMD, bml_pkg::SPI_RD_ADDR}; // see RQ7
			mosi_nxt = bml_pkg::SPI_RD_CMD[7];
			bits_nxt = bml_pkg::CMD_BITS; // see RQ8
			div_nxt  = HALF;
			hi_nxt   = 1'b0;
			busy_nxt = 1'b1;
		end else if (start_byte && !use_flash) begin
			tx_nxt   = 24'h00_0000;
			mosi_nxt = 1'b0;
			bits_nxt = bml_pkg::BYTE_BITS;
			div_nxt  = HALF;
			hi_nxt   = 1'b0;
			busy_nxt = 1'b1;
		end else if (start_byte) begin
			fbank_n_nxt = 1'b0; // see RQ5
			fph_nxt     = bml_pkg::PH_SETUP;
			fcnt_nxt    = setup_r - 4'h1;
			busy_nxt    = 1'b1;
		end
		// Software reset restarts the boot, or bypasses it when enabled
		if (sw_reset_i) begin
			mode_nxt    = pins_s; // see RQ2
			cs_n_nxt    = 1'b1;
			sck_nxt     = 1'b0;
			mosi_nxt    = 1'b0;
			fbank_n_nxt = 1'b1;
			frd_n_nxt   = 1'b1;
			busy_nxt    = 1'b0;
			b_run_nxt   = 1'b0;
			pack_nxt    = 1'b0;
			if (bypass_on_sw_reset_i) begin
				a_pc_nxt  = bml_pkg::L1_START; // see RQ12
				a_run_nxt = 1'b1;
				st_nxt    = bml_pkg::ST_RUN;
			end else begin
				a_run_nxt = 1'b0;
				wait_nxt  = 2'h0;
				st_nxt    = bml_pkg::ST_WAIT;
			end
		end
	end

	// Register the loader state
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_r <= bml_pkg::ST_WAIT;  wait_r <= bml_pkg::SYNC_WAIT;  mode_r <= 2'h0;
			cs_n_r <= 1'b1;  sck_r <= 1'b0;  mosi_r <= 1'b0;  hi_r <= 1'b0;
			tx_r <= 24'h00_0000;  rx_r <= 8'h00;  bits_r <= 5'h00;  div_r <= 4'h0;
			fcnt_r <= 4'h0;  fa_r <= 24'h00_0000;  fbank_n_r <= 1'b1;  frd_n_r <= 1'b1;
			busy_r <= 1'b0;  fph_r <= 2'h0;  hidx_r <= 4'h0;  last_r <= 1'b0;
			blk_addr_r <= 32'h0000_0000;  blk_cnt_r <= 32'h0000_0000;
			setup_r <= 4'h0;  acc_r <= 4'h0;  hold_r <= 4'h0;  pack_r <= 1'b0;
			a_run_r <= 1'b0;  b_run_r <= 1'b0;  a_pc_r <= 32'h0000_0000;
		end else begin
			st_r <= st_nxt;  wait_r <= wait_nxt;  mode_r <= mode_nxt;
			cs_n_r <= cs_n_nxt;  sck_r <= sck_nxt;  mosi_r <= mosi_nxt;  hi_r <= hi_nxt;
			tx_r <= tx_nxt;  rx_r <= rx_nxt;  bits_r <= bits_nxt;  div_r <= div_nxt;
			fcnt_r <= fcnt_nxt;  fa_r <= fa_nxt;  fbank_n_r <= fbank_n_nxt;
			frd_n_r <= frd_n_nxt;  busy_r <= busy_nxt;  fph_r <= fph_nxt;
			hidx_r <= hidx_nxt;  last_r <= last_nxt;
			blk_addr_r <= blk_addr_nxt;  blk_cnt_r <= blk_cnt_nxt;
			setup_r <= setup_nxt;  acc_r <= acc_nxt;  hold_r <= hold_nxt;
			pack_r <= pack_nxt;  a_run_r <= a_run_nxt;  b_run_r <= b_run_nxt;
			a_pc_r <= a_pc_nxt;
		end
	end

	// Payload words wait here so a stalled memory loses nothing
	bml_buf #(.W(40), .DEPTH(2)) u_buf (
		.mclk_i      (mclk_i),
		.reset_n_i   (reset_n_i),
		.flush_i     (sw_reset_i),
		.in_valid_i  (push_v),
		.in_data_i   ({blk_addr_r, byte_v}), // see RQ9
		.in_ready_o  (buf_rdy),
		.out_valid_o (mem_wr_valid_o),
		.out_data_o  ({mem_wr_addr_o, mem_wr_data_o}),
		.out_ready_i (mem_wr_ready_i)
	);

	// Pin and core outputs, all from registers except the constant core B start address
	assign serial_boot_chip_select_flag_n_o = cs_n_r;
	assign spi_sck_o           = sck_r;
	assign spi_mosi_o          = mosi_r;
	assign flash_addr_o        = fa_r;
	assign flash_bank0_sel_n_o = fbank_n_r;
	assign flash_rd_n_o        = frd_n_r;
	assign ext_setup_cyc_o     = setup_r;
	assign ext_access_cyc_o    = acc_r;
	assign ext_hold_cyc_o      = hold_r;
	assign ext_pack16_o        = pack_r;
	assign boot_mode_o         = mode_r;
	assign core_a_run_o        = a_run_r;
	assign core_a_start_addr_o = a_pc_r;
	assign core_b_run_o        = b_run_r;
	assign core_b_start_addr_o = bml_pkg::CORE_B_START; // see RQ11
endmodule
`default_nettype wire

// ---- src/bml_pkg.sv ----
// Constants, state codes and timing figures shared by the boot mode loader
// Summary of operation
// RQ1 - Pin code 00 direct external run, 01 flash boot, 11 serial boot, 10 reserved.
// RQ2 - Boot select pins are captured at power-on reset and at software reset.
// RQ3 - Direct mode skips loading and starts at 0x2000_0000 with 16-bit packing.
// RQ4 - Direct and flash modes use 4 setup, 15 access and 3 hold cycles.
// RQ5 - Flash boot reads all bytes through asynchronous memory bank 0.
// RQ6 - Serial boot drives the dedicated flag output as chip select of one memory.
// RQ7 - Serial boot sends read command, address 0x0000, fills instruction memory from start.
// RQ8 - The serial memory is SPI compatible and takes 16-bit addresses.
// RQ9 - Any number of blocks are loaded, each written to its own destination address.
// RQ10 - After the last block core A starts at 0xFFA0_0000.
// RQ11 - Core B stays held until its hold bit clears, then starts at 0xFF60_0000.
// RQ12 - With bypass bit set, a software reset jumps straight to instruction memory start.
// RQ13 - Chip select stays low from read command until the last block is received.
package bml_pkg;
	// Boot select pin codes
	localparam logic [1:0]  MODE_DIRECT   = 2'h0;
	localparam logic [1:0]  MODE_FLASH    = 2'h1;
	localparam logic [1:0]  MODE_RSVD     = 2'h2;
	localparam logic [1:0]  MODE_SERIAL   = 2'h3;
	// Start addresses
	localparam logic [31:0] EXT_START     = 32'h2000_0000;
	localparam logic [31:0] L1_START      = 32'hFFA0_0000;
	localparam logic [31:0] CORE_B_START  = 32'hFF60_0000;
	// External asynchronous timing, slowest device
	localparam logic [3:0]  EXT_SETUP_CYC = 4'h4;
	localparam logic [3:0]  EXT_ACC_CYC   = 4'hF;
	localparam logic [3:0]  EXT_HOLD_CYC  = 4'h3;
	// Serial read command and start address
	localparam logic [7:0]  SPI_RD_CMD    = 8'h03;
	localparam logic [15:0] SPI_RD_ADDR   = 16'h0000;
	localparam logic [4:0]  CMD_BITS      = 5'h18;
	localparam logic [4:0]  BYTE_BITS     = 5'h08;
	// Serial clock period in ns, and half period in system clocks, rounded up
	localparam int unsigned CLK_MHZ       = 100;
	localparam int unsigned SPI_SCK_PERIOD_NS = 125;
	localparam int unsigned SPI_HALF_CYC  = (SPI_SCK_PERIOD_NS * CLK_MHZ + 1999) / 2000;
	// Cycles to let the pin synchroniser settle before capture
	localparam logic [1:0]  SYNC_WAIT     = 2'h2;
	// Block header: 4 address bytes, 4 count bytes, 1 flag byte, LSB first
	localparam logic [3:0]  HDR_CNT_IDX   = 4'h4;
	localparam logic [3:0]  HDR_FLAG_IDX  = 4'h8;
	localparam int unsigned HDR_LAST_BIT  = 0;
	// Flash access phases
	localparam logic [1:0]  PH_SETUP      = 2'h0;
	localparam logic [1:0]  PH_ACC        = 2'h1;
	localparam logic [1:0]  PH_HOLD       = 2'h2;
	// Loader states
	typedef enum logic [6:0] {
		ST_WAIT  = 7'h01,
		ST_CMD   = 7'h02,
		ST_HDR   = 7'h04,
		ST_PAY   = 7'h08,
		ST_DRAIN = 7'h10,
		ST_RUN   = 7'h20,
		ST_HALT  = 7'h40
	} bml_state_t;
endpackage

// ---- testbench/bml_asserts.sv ----
// Concurrent checks on the boot mode loader ports
`timescale 1ns/1ps
`default_nettype none
module bml_asserts (
	input wire logic        mclk_i,
	input wire logic        reset_n_i,
	input wire logic        sw_reset_i,
	input wire logic        bypass_on_sw_reset_i,
	input wire logic        core_b_hold_i,
	input wire logic        serial_boot_chip_select_flag_n_o,
	input wire logic        spi_sck_o,
	input wire logic        flash_bank0_sel_n_o,
	input wire logic        flash_rd_n_o,
	input wire logic [3:0]  ext_setup_cyc_o,
	input wire logic [3:0]  ext_access_cyc_o,
	input wire logic [3:0]  ext_hold_cyc_o,
	input wire logic        ext_pack16_o,
	input wire logic [1:0]  boot_mode_o,
	input wire logic        mem_wr_valid_o,
	input wire logic        mem_wr_ready_i,
	input wire logic        core_a_run_o,
	input wire logic [31:0] core_a_start_addr_o,
	input wire logic        core_b_run_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	logic [4:0] rd_cnt_r;
	logic [4:0] rd_cnt_nxt;
	// Counts the cycles of the current flash read strobe
	always_comb rd_cnt_nxt = flash_rd_n_o ? 5'h00 : rd_cnt_r + 5'h01;
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) rd_cnt_r <= 5'h00;
		else rd_cnt_r <= rd_cnt_nxt;
	end
	property p_direct;
		core_a_run_o && core_a_start_addr_o == 32'h2000_0000 |-> ext_pack16_o;
	endproperty
	a_direct: assert property (p_direct) else $error("direct packing off");
	property p_timing;
		!flash_bank0_sel_n_o |-> {ext_setup_cyc_o, ext_access_cyc_o, ext_hold_cyc_o} == 12'h4F3;
	endproperty
	a_timing: assert property (p_timing) else $error("flash timing wrong");
	property p_rd_len;
		$rose(flash_rd_n_o) |-> rd_cnt_r == 5'h0F;
	endproperty
	a_rd_len: assert property (p_rd_len) else $error("read strobe length");
	property p_setup;
		$fell(flash_bank0_sel_n_o) |-> ##4 $fell(flash_rd_n_o);
	endproperty
	a_setup: assert property (p_setup) else $error("flash setup length");
	property p_hold;
		$rose(flash_rd_n_o) |-> ##3 $rose(flash_bank0_sel_n_o);
	endproperty
	a_hold: assert property (p_hold) else $error("flash hold length");
	property p_bank;
		!flash_rd_n_o |-> !flash_bank0_sel_n_o;
	endproperty
	a_bank: assert property (p_bank) else $error("read outside bank 0");
	property p_sck_cs;
		spi_sck_o |-> !serial_boot_chip_select_flag_n_o;
	endproperty
	a_sck_cs: assert property (p_sck_cs) else $error("clock without select");
	property p_cs_end;
		$rose(serial_boot_chip_select_flag_n_o) && !$past(sw_reset_i) |-> ##[0:1000] core_a_run_o;
	endproperty
	a_cs_end: assert property (p_cs_end) else $error("select dropped early");
	property p_a_pc;
		$rose(core_a_run_o) && boot_mode_o != 2'h0 |-> core_a_start_addr_o == 32'hFFA0_0000;
	endproperty
	a_a_pc: assert property (p_a_pc) else $error("core a start wrong");
	property p_quiet;
		core_a_run_o |-> !mem_wr_valid_o && serial_boot_chip_select_flag_n_o;
	endproperty
	a_quiet: assert property (p_quiet) else $error("core a run while loading");
	property p_b_cause;
		$rose(core_b_run_o) |-> !$past(core_b_hold_i) && $past(core_a_run_o);
	endproperty
	a_b_cause: assert property (p_b_cause) else $error("core b released early");
	property p_b_go;
		(core_a_run_o && !core_b_hold_i && !sw_reset_i)[*3] |-> core_b_run_o;
	endproperty
	a_b_go: assert property (p_b_go) else $error("core b not released");
	property p_bypass;
		sw_reset_i && bypass_on_sw_reset_i |=> core_a_run_o && core_a_start_addr_o == 32'hFFA0_0000;
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass jump missing");
	property p_stall;
		mem_wr_valid_o && !mem_wr_ready_i && !sw_reset_i |=> mem_wr_valid_o;
	endproperty
	a_stall: assert property (p_stall) else $error("write dropped");
	c_flash: cover property (core_a_run_o && boot_mode_o == 2'h1);
	c_serial: cover property (core_a_run_o && boot_mode_o == 2'h3);
	c_bypass: cover property (sw_reset_i && bypass_on_sw_reset_i);
endmodule
`default_nettype wire

// ---- testbench/bml_mem_model.sv ----
// Boot memory model: serial memory and byte-wide parallel flash on one image
`timescale 1ns/1ps
`default_nettype none
module bml_mem_model (
	input  wire logic        cs_n_i,
	input  wire logic        sck_i,
	input  wire logic        mosi_i,
	output logic             miso_o,
	input  wire logic        bank_n_i,
	input  wire logic        rd_n_i,
	input  wire logic [23:0] addr_i,
	output logic [7:0]       data_o
);
	logic [7:0]  img [0:31];
	logic [23:0] cmd_r;
	logic        out_bit = 1'b0;
	int          nbit;
	int          idx;
	// A new frame restarts the bit count; command and address shift in on rising clock
	always @(negedge cs_n_i or posedge sck_i) begin
		if (!sck_i) begin
			nbit = 0;
		end else if (!cs_n_i) begin
			if (nbit < 24) cmd_r = {cmd_r[22:0], mosi_i};
			nbit++;
		end
	end
	// Sequential read data shifts out MSB first on falling clock
	always @(negedge sck_i) begin
		if (!cs_n_i && nbit >= 24) begin
			idx = (int'(cmd_r[15:0]) + (nbit - 24) / 8) % 32;
			out_bit = img[idx][7 - (nbit - 24) % 8];
		end
	end
	// Deselected serial line shows the inverse of the last bit; flash data not being read shows the inverse of the addressed byte
	assign miso_o = cs_n_i ? ~out_bit : out_bit;
	assign data_o = (!bank_n_i && !rd_n_i) ? img[addr_i[4:0]] : ~img[addr_i[4:0]];
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench for the boot mode loader
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        clk, rst_n, swr, byp, hold, miso, stall;
	logic        ready = 1'b1;
	logic        cs_n, sck, mosi, bank_n, rd_n, pack, valid, a_run, b_run;
	logic [1:0]  pins, mode;
	logic [23:0] faddr;
	logic [7:0]  fdata, wdata;
	logic [3:0]  setup, acc, hld;
	logic [31:0] waddr, a_pc, b_pc;
	int          num_errors, checks;
	int          cyc = 0;
	logic [7:0]  img_q[$];
	logic [39:0] exp_q[$], got_q[$];
	bml_loader bml_loader_inst (.mclk_i(clk), .reset_n_i(rst_n), .sw_reset_i(swr),
		.bypass_on_sw_reset_i(byp), .core_b_hold_i(hold), .boot_select_pins_i(pins),
		.serial_boot_chip_select_flag_n_o(cs_n), .spi_sck_o(sck), .spi_mosi_o(mosi),
		.spi_miso_i(miso), .flash_addr_o(faddr), .flash_bank0_sel_n_o(bank_n),
		.flash_rd_n_o(rd_n), .flash_data_i(fdata), .ext_setup_cyc_o(setup),
		.ext_access_cyc_o(acc), .ext_hold_cyc_o(hld), .ext_pack16_o(pack),
		.boot_mode_o(mode), .mem_wr_valid_o(valid), .mem_wr_addr_o(waddr),
		.mem_wr_data_o(wdata), .mem_wr_ready_i(ready), .core_a_run_o(a_run),
		.core_a_start_addr_o(a_pc), .core_b_run_o(b_run), .core_b_start_addr_o(b_pc));
	bml_mem_model bml_mem_model_inst (.cs_n_i(cs_n), .sck_i(sck), .mosi_i(mosi),
		.miso_o(miso), .bank_n_i(bank_n), .rd_n_i(rd_n), .addr_i(faddr), .data_o(fdata));
	// Clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Memory side: rare ready while stalling, and a log of accepted writes
	always @(posedge clk) begin
		if (valid && ready) got_q.push_back({waddr, wdata});
		cyc <= cyc + 1;
		ready <= #1 !stall || (cyc % 150 == 0);
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Appends one block to the image and its payload to the expected writes
	task automatic put_block(input logic [31:0] d, input int n, input logic last);
		for (int i = 0; i < 4; i++) img_q.push_back(d[8*i+:8]);
		for (int i = 0; i < 4; i++) img_q.push_back(8'(n >> (8 * i)));
		img_q.push_back({7'h00, last});
		for (int i = 0; i < n; i++) begin
			img_q.push_back(8'h5A ^ 8'(i * 7 + n));
			exp_q.push_back({d + 32'(i), 8'h5A ^ 8'(i * 7 + n)});
		end
	endtask
	task automatic boot(input logic [1:0] p);
		rst_n = 1'b0;
		pins = p;
		got_q.delete();
		tick(6);
		rst_n = 1'b1;
		tick(5);
	endtask
	task automatic t_direct();
		boot(2'h0);
		chk("mode", 64'(mode), 64'h0);
		chk("run_a", 64'(a_run), 64'h1);
		chk("pc_a", 64'(a_pc), 64'h2000_0000);
		chk("pack", 64'(pack), 64'h1);
		chk("timing", 64'({setup, acc, hld}), 64'h4F3);
	endtask
	task automatic t_reserved();
		boot(2'h2);
		tick(300);
		chk("idle", 64'({a_run, cs_n, bank_n, valid}), 64'h6);
	endtask
	// Loads the image with the memory stalling, then releases both cores
	task automatic t_load(input logic [1:0] p);
		hold = 1'b1;
		stall = 1'b1;
		boot(p);
		chk("select", 64'({cs_n, bank_n}), p == 2'h3 ? 64'h1 : 64'h2);
		for (int i = 0; i < 20000 && a_run !== 1'b1; i++) tick(1);
		chk("run_a", 64'(a_run), 64'h1);
		chk("pc_a", 64'(a_pc), 64'hFFA0_0000);
		chk("writes", 64'(got_q.size()), 64'(exp_q.size()));
		foreach (exp_q[i]) chk("write", 64'(got_q[i]), 64'(exp_q[i]));
		if (p == 2'h3) chk("cmd", 64'(bml_mem_model_inst.cmd_r), 64'h03_0000);
		else chk("timing", 64'({setup, acc, hld}), 64'h4F3);
		chk("run_b", 64'(b_run), 64'h0);
		hold = 1'b0;
		tick(3);
		chk("run_b", 64'(b_run), 64'h1);
		chk("pc_b", 64'(b_pc), 64'hFF60_0000);
		stall = 1'b0;
	endtask
	// Software reset with bypass, then a plain one that recaptures the pins
	task automatic t_sw();
		byp = 1'b1;
		got_q.delete();
		swr = 1'b1;
		tick(1);
		swr = 1'b0;
		chk("pc_a", 64'({a_run, a_pc}), 64'h1_FFA0_0000);
		tick(300);
		chk("quiet", 64'({cs_n, got_q.size() == 0}), 64'h3);
		byp = 1'b0;
		pins = 2'h1;
		tick(3);
		swr = 1'b1;
		tick(1);
		swr = 1'b0;
		chk("run_a", 64'(a_run), 64'h0);
		tick(30);
		chk("mode", 64'(mode), 64'h1);
	endtask
	task automatic summarize();
		if (num_errors == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		rst_n = 1'b0;
		swr = 1'b0;
		byp = 1'b0;
		hold = 1'b1;
		stall = 1'b0;
		pins = 2'h0;
		num_errors = 0;
		checks = 0;
		put_block(32'hFFA0_0000, 3, 1'b0);
		put_block(32'hFF80_0010, 0, 1'b0);
		put_block(32'h0000_1000, 2, 1'b1);
		foreach (img_q[i]) bml_mem_model_inst.img[i] = img_q[i];
		t_direct();
		t_reserved();
		t_load(2'h1);
		t_load(2'h3);
		t_sw();
		summarize();
	end
	// Watchdog
	initial begin
		repeat (60000) @(posedge clk);
		num_errors++;
		summarize();
	end
endmodule
bind bml_loader bml_asserts bml_asserts_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
	.sw_reset_i(sw_reset_i), .bypass_on_sw_reset_i(bypass_on_sw_reset_i),
	.core_b_hold_i(core_b_hold_i), .spi_sck_o(spi_sck_o),
	.serial_boot_chip_select_flag_n_o(serial_boot_chip_select_flag_n_o),
	.flash_bank0_sel_n_o(flash_bank0_sel_n_o), .flash_rd_n_o(flash_rd_n_o),
	.ext_setup_cyc_o(ext_setup_cyc_o), .ext_access_cyc_o(ext_access_cyc_o),
	.ext_hold_cyc_o(ext_hold_cyc_o), .ext_pack16_o(ext_pack16_o), .boot_mode_o(boot_mode_o),
	.mem_wr_valid_o(mem_wr_valid_o), .mem_wr_ready_i(mem_wr_ready_i),
	.core_a_run_o(core_a_run_o), .core_a_start_addr_o(core_a_start_addr_o),
	.core_b_run_o(core_b_run_o));
`default_nettype wire
